// ### design/psb_slave.sv
// Slave front end of a double-data-rate pseudo static RAM bus, with Wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "psb_params.svh"

// Function
// RL1: Select falling starts a transaction and command/address capture.
// RL2: Select rising ends the transaction, aborting any burst in progress.
// RL3: Host gives every slave its own select line.
// RL4: Single-ended clock uses only the true input; complement ignored.
// RL5: Differential clock edges are taken at true/complement crossings.
// RL6: Bus clock may stop outside transactions; no free-running clock assumed.
// RL7: Command, address and data share the eight-bit data bus.
// RL8: Device drives strobe during command/address to signal extra latency.
// RL9: On reads device drives strobe; each byte changes with a strobe edge.
// RL10: On writes the host drives strobe as byte mask; device only listens.
// RL11: Doubled initial latency always applies; single latency never used.
// RL12: Hardware reset low reinitialises the device back to standby.
// RL13: Hardware reset low puts strobe and data lines in high impedance.
// RL14: Host lowers select only while clock idles low, complement high.
// RL15: First six clock edges carry 48 command/address bits.
// RL16: Command/address bytes arrive most significant first, bit 7 on line 7.
// RL17: Decode direction, space, burst type, row and word addresses.
// RL18: Register-space transactions reach identification and configuration registers.
// RL19: Bit 47 high is a read, low a write.
// RL20: Bit 46 low is memory array, high register space.
// RL21: Bit 45 low is wrapped burst, high linear burst.
// RL22: Write byte with strobe high is masked; strobe low is written.
// RL23: Select high keeps bus tristated and clock and data ignored.
module psb_slave
    import psb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire psb_pin_in_t pins_i,
    output psb_pin_out_t pins_o
);

    // ============================================================
    // Helpers

    // Byte-lane merge for Wishbone writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Byte A is the high half of a word, byte B the low half
    function automatic logic [7:0] word_byte(input logic [15:0] w, input logic second);
        return second ? w[7:0] : w[15:8];
    endfunction

    // ============================================================
    // Pin synchronisers
    localparam int PW = $bits(psb_pin_in_t);
    logic [PW-1:0] sync1_q, sync2_q, sync3_q;
    psb_pin_in_t pin_q;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= '1;
            sync2_q <= '1;
            sync3_q <= '1;
        end else if (ce_i) begin
            sync1_q <= pins_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Filtered pin levels, idle values after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_q <= '{cs_n: 1'b1, rst_n: 1'b1, clk_p: 1'b0, clk_n: 1'b1,
                       rd_wr_strobe: 1'b0, dq: 8'h00};
        end else if (ce_i) begin
            for (int i = 0; i < PW; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    pin_q[i] <= sync3_q[i];
                end
            end
        end
    end

    // ============================================================
    // Software registers
    logic [31:0] ctrl_q;
    logic [15:0] rd_word_q;
    logic wr_acc;
    logic wb_req;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_acc = wb_req && wb_we_i;

    // Control and read word; core only reads them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `PSB_CTRL_RST;
            rd_word_q <= `PSB_RD_WORD_RST;
        end else if (ce_i && wr_acc) begin
            if (wb_adr_i == `PSB_ADR_CTRL) begin
                ctrl_q <= lane_merge(ctrl_q, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == `PSB_ADR_RD_WORD) begin
                rd_word_q <= 16'(lane_merge({16'h0000, rd_word_q}, wb_dat_i, wb_sel_i));
            end
        end
    end

    // ============================================================
    // Bus clock recovery
    logic clk_lvl_d, clk_lvl_q, clk_edge;

    // Differential level moves only at a crossing; single-ended reads the true pin
    always_comb begin
        clk_lvl_d = clk_lvl_q;
        if (!ctrl_q[`PSB_CTRL_DIFF]) begin
            clk_lvl_d = pin_q.clk_p;                      // see RL4
        end else if (pin_q.clk_p != pin_q.clk_n) begin
            clk_lvl_d = pin_q.clk_p;                      // see RL5
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_lvl_q <= 1'b0;
        end else if (ce_i) begin
            clk_lvl_q <= clk_lvl_d;
        end
    end

    // Edges matter only while selected, so a stopped clock is harmless
    assign clk_edge = (clk_lvl_d != clk_lvl_q) && !pin_q.cs_n; // see RL6 see RL23

    // ============================================================
    // Select tracking
    logic cs_prev_q, cs_fall, cs_rise, hw_rst;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_prev_q <= 1'b1;
        end else if (ce_i) begin
            cs_prev_q <= pin_q.cs_n;
        end
    end

    assign cs_fall = cs_prev_q && !pin_q.cs_n;            // see RL1
    assign cs_rise = !cs_prev_q && pin_q.cs_n;            // see RL2
    assign hw_rst = !pin_q.rst_n;

    // ============================================================
    // Transaction sequencer
    psb_state_t state_q;
    logic [2:0] ca_cnt_q;
    logic [47:0] ca_q;
    logic [47:0] ca_next;
    logic [5:0] lat_cnt_q;
    logic [5:0] lat_edges;
    logic phase_q;
    logic ca_done_q;

    // Doubled latency: four edges per latency clock, single option ignored
    assign lat_edges = {ctrl_q[`PSB_CTRL_LAT_MSB:`PSB_CTRL_LAT_LSB], 2'b00}; // see RL11
    assign ca_next = {ca_q[39:0], pin_q.dq};              // see RL7 see RL16

    always_ff @(posedge clk_i) begin
        if (rst_i || hw_rst) begin
            state_q <= st_idle;                           // see RL12
        end else if (ce_i) begin
            unique case (state_q)
                st_idle: begin
                    if (cs_fall) begin
                        state_q <= st_ca;
                    end
                end
                st_ca: begin
                    if (cs_rise) begin
                        state_q <= st_idle;
                    end else if (clk_edge && ca_cnt_q == `PSB_CA_LAST) begin
                        // Register writes carry no latency
                        if (!ca_next[`PSB_CA_DIR] && ca_next[`PSB_CA_SPACE]) begin
                            state_q <= st_write;
                        end else begin
                            state_q <= st_lat;
                        end
                    end
                end
                st_lat: begin
                    if (cs_rise) begin
                        state_q <= st_idle;
                    end else if (clk_edge && lat_cnt_q == 6'd1) begin
                        state_q <= ca_q[`PSB_CA_DIR] ? st_read : st_write; // see RL19
                    end
                end
                st_read, st_write, st_wait_end: begin
                    if (cs_rise) begin
                        state_q <= st_idle;               // see RL2
                    end
                end
                default: begin
                    state_q <= st_idle;
                end
            endcase
        end
    end

    // Command/address capture over six edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ca_cnt_q <= 3'd0;
            ca_q <= 48'h0;
        end else if (ce_i) begin
            if (cs_fall) begin
                ca_cnt_q <= 3'd0;
            end else if (state_q == st_ca && clk_edge && ca_cnt_q != `PSB_CA_EDGES) begin
                ca_cnt_q <= ca_cnt_q + 3'd1;              // see RL15
                ca_q <= ca_next;
            end
        end
    end

    // Latency countdown in bus clock edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_cnt_q <= 6'd0;
        end else if (ce_i) begin
            if (state_q == st_ca) begin
                lat_cnt_q <= (lat_edges == 6'd0) ? 6'd1 : lat_edges;
            end else if (state_q == st_lat && clk_edge) begin
                lat_cnt_q <= lat_cnt_q - 6'd1;
            end
        end
    end

    // Sticky capture flag: set beats a software clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ca_done_q <= 1'b0;
        end else if (ce_i) begin
            if (state_q == st_ca && clk_edge && ca_cnt_q == `PSB_CA_LAST) begin
                ca_done_q <= 1'b1;
            end else if (wr_acc && wb_adr_i == `PSB_ADR_STAT && wb_sel_i[0] && wb_dat_i[0]) begin
                ca_done_q <= 1'b0;
            end
        end
    end

    // ============================================================
    // Decoded command fields
    logic dec_read, dec_reg_space, dec_linear;
    logic [28:0] dec_row;
    logic [2:0] dec_col;

    assign dec_read = ca_q[`PSB_CA_DIR];                  // see RL17 see RL19
    assign dec_reg_space = ca_q[`PSB_CA_SPACE];           // see RL20 see RL18
    assign dec_linear = ca_q[`PSB_CA_BURST];              // see RL21
    assign dec_row = ca_q[`PSB_CA_ROW_MSB:`PSB_CA_ROW_LSB];
    assign dec_col = ca_q[`PSB_CA_COL_MSB:0];

    // ============================================================
    // Data phase
    logic [15:0] wr_word_q;
    logic [1:0] wr_mask_q;
    logic [7:0] wr_hi_q;
    logic wr_hi_mask_q;
    logic [31:0] wr_cnt_q;

    // Byte phase: A then B of each word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= 1'b0;
        end else if (ce_i) begin
            if (state_q != st_read && state_q != st_write) begin
                phase_q <= 1'b0;
            end else if (clk_edge) begin
                phase_q <= !phase_q;
            end
        end
    end

    // Write capture; strobe high masks the byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_word_q <= 16'h0000;
            wr_mask_q <= 2'b00;
            wr_hi_q <= 8'h00;
            wr_hi_mask_q <= 1'b0;
            wr_cnt_q <= 32'h0;
        end else if (ce_i && state_q == st_write && clk_edge) begin
            if (!phase_q) begin
                wr_hi_q <= pin_q.dq;
                wr_hi_mask_q <= pin_q.rd_wr_strobe;               // see RL10
            end else begin
                wr_mask_q <= {wr_hi_mask_q, pin_q.rd_wr_strobe};
                // Masked bytes keep their old value
                if (!wr_hi_mask_q) begin
                    wr_word_q[15:8] <= wr_hi_q;           // see RL22
                end
                if (!pin_q.rd_wr_strobe) begin
                    wr_word_q[7:0] <= pin_q.dq;           // see RL22
                end
                wr_cnt_q <= wr_cnt_q + 32'd1;
            end
        end
    end

    // ============================================================
    // Pin drivers, all from flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i || hw_rst) begin
            pins_o <= '{dq: 8'h00, dq_oe: 1'b0, rd_wr_strobe: 1'b0, rd_wr_strobe_oe: 1'b0}; // see RL13
        end else if (ce_i) begin
            if (pin_q.cs_n || cs_rise) begin
                pins_o <= '{dq: 8'h00, dq_oe: 1'b0, rd_wr_strobe: 1'b0, rd_wr_strobe_oe: 1'b0}; // see RL23
            end else begin
                unique case (state_q)
                    st_ca: begin
                        // Latency always doubled, so strobe reports high
                        pins_o.rd_wr_strobe_oe <= 1'b1;           // see RL8
                        pins_o.rd_wr_strobe <= 1'b1;              // see RL11
                        pins_o.dq_oe <= 1'b0;
                    end
                    st_lat: begin
                        pins_o.rd_wr_strobe_oe <= dec_read;
                        pins_o.rd_wr_strobe <= 1'b0;
                        pins_o.dq_oe <= 1'b0;
                    end
                    st_read: begin
                        pins_o.rd_wr_strobe_oe <= 1'b1;
                        pins_o.dq_oe <= 1'b1;
                        if (clk_edge) begin
                            // Byte and strobe move together
                            pins_o.dq <= word_byte(rd_word_q, phase_q); // see RL9
                            pins_o.rd_wr_strobe <= !phase_q;      // see RL9
                        end
                    end
                    st_idle, st_write, st_wait_end: begin
                        pins_o.rd_wr_strobe_oe <= 1'b0;           // see RL10
                        pins_o.dq_oe <= 1'b0;
                        pins_o.rd_wr_strobe <= 1'b0;
                    end
                    default: begin
                        pins_o.rd_wr_strobe_oe <= 1'b0;
                        pins_o.dq_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ============================================================
    // Wishbone answer: one wait-free cycle, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    `PSB_ADR_CTRL: wb_dat_o <= ctrl_q;
                    `PSB_ADR_STAT: wb_dat_o <= {17'h00000, dec_col, dec_linear,
                                                dec_reg_space, dec_read, 4'h0,
                                                1'(state_q == st_idle), state_q,
                                                ca_done_q};
                    `PSB_ADR_CA_HI: wb_dat_o <= {3'b000, dec_row};
                    `PSB_ADR_CA_LO: wb_dat_o <= {16'h0000, ca_q[15:0]};
                    `PSB_ADR_RD_WORD: wb_dat_o <= {16'h0000, rd_word_q};
                    `PSB_ADR_WR_WORD: wb_dat_o <= {14'h0000, wr_mask_q, wr_word_q};
                    `PSB_ADR_WR_CNT: wb_dat_o <= wr_cnt_q;
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ### design/psb_params.svh
// Register offsets, field positions, reset values and counts of the bus slave front end
`ifndef PSB_PARAMS_SVH
`define PSB_PARAMS_SVH

// ============================================================
// Register byte offsets on the Wishbone slave
`define PSB_ADR_CTRL 8'h00
`define PSB_ADR_STAT 8'h04
`define PSB_ADR_CA_HI 8'h08
`define PSB_ADR_CA_LO 8'h0c
`define PSB_ADR_RD_WORD 8'h10
`define PSB_ADR_WR_WORD 8'h14
`define PSB_ADR_WR_CNT 8'h18

// ============================================================
// Control fields and reset values
`define PSB_CTRL_DIFF 0
`define PSB_CTRL_SINGLE_LAT 1
`define PSB_CTRL_LAT_LSB 4
`define PSB_CTRL_LAT_MSB 7
`define PSB_CTRL_RST 32'h0000_0060
`define PSB_RD_WORD_RST 16'h0000

// ============================================================
// Command/address field positions
`define PSB_CA_DIR 47
`define PSB_CA_SPACE 46
`define PSB_CA_BURST 45
`define PSB_CA_ROW_MSB 44
`define PSB_CA_ROW_LSB 16
`define PSB_CA_COL_MSB 2

// ============================================================
// Counts
`define PSB_CA_EDGES 3'd6
`define PSB_CA_LAST 3'd5

`endif

// ### design/psb_pkg.sv
// Types shared by the bus slave front end
package psb_pkg;

    // ============================================================
    // Pin groups as seen by the core
    typedef struct packed {
        logic cs_n;
        logic rst_n;
        logic clk_p;
        logic clk_n;
        logic rd_wr_strobe;
        logic [7:0] dq;
    } psb_pin_in_t;

    typedef struct packed {
        logic [7:0] dq;
        logic dq_oe;
        logic rd_wr_strobe;
        logic rd_wr_strobe_oe;
    } psb_pin_out_t;

    // ============================================================
    // Transaction phases
    typedef enum logic [2:0] {
        st_idle,
        st_ca,
        st_lat,
        st_read,
        st_write,
        st_wait_end
    } psb_state_t;

endpackage

// ### testbench/psb_slave_props.sv
// Port checker for the bus slave front end
`timescale 1ns/1ps
`default_nettype none
module psb_slave_props
    import psb_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire psb_pin_in_t pins_i,
    input wire psb_pin_out_t pins_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // =====
    // Register bus handshake
    a_ack_answers_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("no ack after request");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");

    // =====
    // Memory bus pins
    a_quiet_deselect: assert property (pins_i.cs_n [*8] |-> !pins_o.dq_oe && !pins_o.rd_wr_strobe_oe)
        else $error("bus driven while deselected");
    a_quiet_reset: assert property (!pins_i.rst_n [*8] |-> pins_o == '0)
        else $error("bus driven during pin reset");
    a_strobe_needs_cs: assert property ($rose(pins_o.rd_wr_strobe_oe) |-> !pins_i.cs_n && !$past(pins_i.cs_n, 3))
        else $error("strobe driven without select");
    a_strobe_ca_high: assert property ($rose(pins_o.rd_wr_strobe_oe) |-> pins_o.rd_wr_strobe)
        else $error("strobe low at command phase");
    a_read_strobe_on: assert property (pins_o.dq_oe |-> pins_o.rd_wr_strobe_oe)
        else $error("read data without strobe");
    a_byte_on_strobe: assert property (pins_o.dq_oe && $changed(pins_o.dq) |-> $changed(pins_o.rd_wr_strobe))
        else $error("read byte moved without strobe edge");
endmodule
`default_nettype wire

// ### testbench/psb_host_model.sv
// Host controller model driving the memory bus pins
`timescale 1ns/1ps
`default_nettype none
module psb_host_model
    import psb_pkg::*;
(
    input wire logic clk_i,
    input wire psb_pin_out_t pins_o,
    output var psb_pin_in_t pins_i
);
    logic cs_n, rst_n, ck, ckn, diff, flip, last_rw, last_oe, h_dq_oe, h_rw_oe, h_rw;
    logic [7:0] h_dq;
    logic [8:0] rd_q[$];

    // =====
    // Wire levels
    initial begin
        {cs_n, rst_n, ck, ckn, diff, flip, last_rw, last_oe} = 8'b1101_0000;
        {h_dq_oe, h_rw_oe, h_rw, h_dq} = 11'h0;
    end
    // Released lines flip every cycle so a stale byte never passes as data
    always @(posedge clk_i) flip <= ~flip;
    assign pins_i = {cs_n, rst_n, ck, diff ? ckn : flip,
        pins_o.rd_wr_strobe_oe ? pins_o.rd_wr_strobe : (h_rw_oe ? h_rw : flip),
        pins_o.dq_oe ? pins_o.dq : (h_dq_oe ? h_dq : {8{flip}} ^ 8'h5a)};

    // Read byte log, one entry per strobe transition
    always @(posedge clk_i) begin
        // Only a strobe move while already driving marks a byte; the stale
        // level seen when the bus is first turned round is not data
        if (pins_o.dq_oe && last_oe && pins_o.rd_wr_strobe != last_rw) begin
            rd_q.push_back({pins_o.rd_wr_strobe, pins_o.dq});
        end
        last_oe <= pins_o.dq_oe;
        last_rw <= pins_o.rd_wr_strobe;
    end

    // =====
    // Bus cycles; half period is four system clocks, data set mid-half
    task tick(input logic [7:0] d, input logic dq_on, input logic r, input logic r_on);
        h_dq <= d;
        h_dq_oe <= dq_on;
        h_rw <= r;
        h_rw_oe <= r_on;
        repeat (2) @(posedge clk_i);
        ck <= ~ck;
        ckn <= ck;
        repeat (2) @(posedge clk_i);
    endtask

    task run(input logic [47:0] ca, input int nl, input int nd, input logic [15:0] w,
             input logic [1:0] m, input logic dif, input logic hrst);
        int i;
        rd_q.delete();
        @(posedge clk_i);
        diff <= dif;
        cs_n <= 1'b0;
        repeat (6) @(posedge clk_i);
        for (i = 0; i < 6; i++) tick(ca[47 - 8 * i -: 8], 1'b1, 1'b0, 1'b0);
        h_dq_oe <= 1'b0;
        if (hrst) begin
            rst_n <= 1'b0;
            repeat (12) @(posedge clk_i);
            rst_n <= 1'b1;
        end else begin
            for (i = 0; i < nl; i++) tick(8'h00, 1'b0, 1'b0, 1'b0);
            for (i = 0; i < nd; i++) tick(i[0] ? w[7:0] : w[15:8], !ca[47],
                                          i[0] ? m[0] : m[1], !ca[47]);
        end
        repeat (6) @(posedge clk_i);
        h_dq_oe <= 1'b0;
        h_rw_oe <= 1'b0;
        cs_n <= 1'b1;
        // Odd edge count leaves the clock high; park it while deselected
        if (ck) begin
            repeat (8) @(posedge clk_i);
            ck <= 1'b0;
            ckn <= 1'b1;
        end
        repeat (16) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// ### testbench/tb_psram_bus_slave_front_end.sv
// Self-checking bench for the bus slave front end
`timescale 1ns/1ps
`default_nettype none
`include "psb_params.svh"
module tb_psram_bus_slave_front_end
    import psb_pkg::*;
;
    logic clk_i, rst_i, ce_i, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat, wb_q, q, cnt, cv;
    logic [47:0] ca;
    logic [15:0] w, rdw, ww;
    logic [1:0] m;
    int n_mismatch, compares, k, i, lat, nd;
    psb_pin_in_t pins_i;
    psb_pin_out_t pins_o;

    psb_slave dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .pins_i(pins_i), .pins_o(pins_o));
    psb_host_model host (.clk_i(clk_i), .pins_o(pins_o), .pins_i(pins_i));

    // =====
    // Clock and watchdog
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Whole run needs about 1100 cycles; this leaves a wide margin
    initial begin
        #200000;
        n_mismatch++;
        results();
    end

    // =====
    // Checking and bus tasks
    function logic [15:0] merge(input logic [15:0] o, input logic [15:0] n, input logic [1:0] mk);
        merge = {mk[1] ? o[15:8] : n[15:8], mk[0] ? o[7:0] : n[7:0]};
    endfunction
    function logic [31:0] stat_exp(input logic [47:0] c);
        stat_exp = {17'h0, c[2:0], c[45], c[46], c[47], 4'h0, 1'b1, 3'h0, 1'b1};
    endfunction
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Classic cycle: hold until ack is sampled, then drop for one cycle
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 40);
        q = wb_q;
        if (n >= 40) chk("wb_ack", 32'h1, 32'h0);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task rdc(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk);
        wb(1'b0, a, 32'h0, 4'hf);
        chk(nm, e & mk, q & mk);
    endtask
    task results;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // =====
    // Main sequence
    initial begin
        void'($urandom(26830));
        {ce_i, rst_i, wb_cyc, wb_stb, wb_we} = 5'b11000;
        {wb_adr, wb_sel, wb_dat} = 44'h0;
        {n_mismatch, compares, cnt, ww} = '0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset values, an unmapped slot, read word with random lanes
        rdc("ctrl", `PSB_ADR_CTRL, `PSB_CTRL_RST, 32'hffffffff);
        rdc("stat", `PSB_ADR_STAT, 32'h10, 32'h1f);
        wb(1'b1, 8'h1c, $urandom, 4'hf);
        rdc("unmapped", 8'h1c, 32'h0, 32'hffffffff);
        w = 16'($urandom);
        m = 2'($urandom);
        wb(1'b1, `PSB_ADR_RD_WORD, {16'h0, w}, {2'b11, m});
        rdw = merge(`PSB_RD_WORD_RST, w, ~m);
        rdc("rd_word", `PSB_ADR_RD_WORD, {16'h0, rdw}, 32'hffff);
        $display("test reset done");
        // Every direction, space and burst combination, then abort and pin reset
        for (k = 0; k < 10; k++) begin
            ca = 48'({$urandom, $urandom});
            ca[47:45] = (k == 8) ? 3'b101 : k[2:0];
            w = 16'($urandom);
            m = 2'($urandom);
            lat = 1 + k % 2;
            nd = (k == 8) ? 3 : 4;
            cv = {24'h0, 4'(lat), 2'b00, 2'($urandom)};
            wb(1'b1, `PSB_ADR_CTRL, cv, 4'hf);
            rdc("ctrl", `PSB_ADR_CTRL, cv, 32'hf3);
            host.run(ca, (ca[46] && !ca[47]) ? 0 : 4 * lat, nd, w, m, cv[0], k == 9);
            rdc("stat", `PSB_ADR_STAT, stat_exp(ca), 32'h7e1f);
            rdc("ca_hi", `PSB_ADR_CA_HI, {3'h0, ca[44:16]}, 32'hffffffff);
            rdc("ca_lo", `PSB_ADR_CA_LO, {16'h0, ca[15:0]}, 32'hffffffff);
            wb(1'b1, `PSB_ADR_STAT, 32'h1, 4'hf);
            rdc("stat_clear", `PSB_ADR_STAT, 32'h0, 32'h1);
            if (!ca[47] && k < 9) begin
                ww = merge(ww, w, m);
                cnt = cnt + 2;
                rdc("wr_word", `PSB_ADR_WR_WORD, {14'h0, m, ww}, 32'h3ffff);
                rdc("wr_cnt", `PSB_ADR_WR_CNT, cnt, 32'hffffffff);
            end
            if (ca[47] && k < 9) begin
                chk("rd_bytes", 32'(nd), 32'(host.rd_q.size()));
                for (i = 0; i < host.rd_q.size() && i < 4; i++) begin
                    chk("rd_byte", {23'h0, ~i[0], i[0] ? rdw[7:0] : rdw[15:8]},
                        {23'h0, host.rd_q[i]});
                end
            end
            $display("test %0d done", k);
        end
        results();
    end
endmodule

bind psb_slave psb_slave_props u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pins_i(pins_i), .pins_o(pins_o));
`default_nettype wire
